// ===== hw/gfc_counter.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE_01 - divide the 10 MHz reference by five to a 2 MHz timebase
// RULE_02 - timebase clocks gate timer; its output is the count gate
// RULE_03 - gate lasts 200 ms, 20 ms or 2 ms by resolution
// RULE_04 - resolution selectable in decades from 10 Hz to 1 MHz
// RULE_05 - only edges while count gate is high are counted
// RULE_06 - frequency input is ANDed with the count gate
// RULE_07 - gated edges drive two 4-bit stages forming a readable 8-bit prescaler
// RULE_08 - prescaler top bit clocks the event timer, counting multiples of 256
// RULE_09 - event timer overflow sets overflow flip-flop and overflow request
// RULE_10 - with acknowledge high, gate end sets count-complete request
// RULE_11 - active-low prescaler read strobe puts prescaler bits on data bus
// RULE_12 - timer select and timer read both low present timer data
// RULE_13 - acknowledge written low clears count-complete request
// RULE_14 - nominal input is 5.35 MHz, half the intermediate frequency
// RULE_15 - reset clears both request flip-flops and the prescaler
module gfc_counter
	import gfc_pkg::*;
#(
	parameter int unsigned EVT_BITS = EVT_W
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                sys_rst_i,
	// measurement control
	input  wire logic                start_i,
	input  wire logic [2:0]          res_i,
	input  wire logic                freq_in_i,
	// processor side
	input  wire logic                prescaler_read_n_i,
	input  wire logic                timer_select_n_i,
	input  wire logic                timer_read_n_i,
	input  wire logic                ack_wr_i,
	input  wire logic                ack_data_i,
	output logic [EVT_BITS-1:0]      board_data_bus_o,
	output logic                     board_data_bus_oe_o,
	// status
	output logic                     count_gate_o,
	output logic                     overflow_irq_o,
	output logic                     count_done_irq_o,
	output logic                     count_done_ack_o
);
	gfc_cnt_if cif ();

	gfc_res_e res;
	logic     fin_q, fin_d;
	logic     gate_q;
	logic [EVT_BITS-1:0] evt_q, evt_d;
	logic     ovf_q, ovf_d, done_q, done_d, ack_q, ack_d;
	logic [EVT_BITS-1:0] bus_d;
	logic     oe_d;
	logic     edge_in;

	assign res = (res_i > 3'(GFC_RES_1MHZ)) ? GFC_RES_1MHZ : gfc_res_e'(res_i);

	gfc_gate_timer u_gate (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (start_i),
		.res_i     (res),
		.g         (cif.gate)
	);

	gfc_prescaler u_pre (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.p         (cif.pre)
	);

	// rising input edge passes only while the gate is high
	assign edge_in = freq_in_i && !fin_q && cif.count_gate; //RULE_05 RULE_06
	assign cif.edge_in = edge_in;
	// prescaler restarts at each new window
	assign cif.clr = start_i && !cif.count_gate;

	always_comb begin
		fin_d = freq_in_i;
		evt_d = evt_q;
		ovf_d = ovf_q;
		done_d = done_q;
		ack_d = ack_q;
		if (cif.clr) evt_d = '0;
		else if (cif.msb_fall) evt_d = evt_q + 1'b1; //RULE_08
		// set wins over clear
		if (cif.msb_fall && evt_q == '1) ovf_d = 1'b1; //RULE_09
		else if (cif.clr) ovf_d = 1'b0;
		if (ack_wr_i) ack_d = ack_data_i;
		if (gate_q && !cif.count_gate && ack_q) done_d = 1'b1; //RULE_10
		else if (!ack_q) done_d = 1'b0; //RULE_13
		bus_d = '0;
		oe_d  = 1'b0;
		if (!prescaler_read_n_i) begin //RULE_11
			bus_d = EVT_BITS'(cif.pre_val);
			oe_d  = 1'b1;
		end else if (!timer_select_n_i && !timer_read_n_i) begin //RULE_12
			bus_d = evt_q;
			oe_d  = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin //RULE_15
			fin_q  <= 1'b0;
			gate_q <= 1'b0;
			evt_q  <= EVT_RST[EVT_BITS-1:0];
			ovf_q  <= 1'b0;
			done_q <= 1'b0;
			ack_q  <= 1'b0;
			board_data_bus_o    <= '0;
			board_data_bus_oe_o <= 1'b0;
			count_gate_o        <= 1'b0;
		end else begin
			fin_q  <= fin_d;
			gate_q <= cif.count_gate;
			evt_q  <= evt_d;
			ovf_q  <= ovf_d;
			done_q <= done_d;
			ack_q  <= ack_d;
			board_data_bus_o    <= bus_d;
			board_data_bus_oe_o <= oe_d;
			count_gate_o        <= cif.count_gate;
		end
	end

	assign overflow_irq_o   = ovf_q;
	assign count_done_irq_o = done_q;
	assign count_done_ack_o = ack_q;

	AST_NO_EDGE_OUTSIDE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!cif.count_gate |-> !edge_in)
		else $error("edge counted outside gate"); //RULE_05
	AST_DONE_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(gate_q && !cif.count_gate && ack_q) |=> count_done_irq_o)
		else $error("count done not raised"); //RULE_10
	AST_DONE_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!ack_q && !(gate_q && !cif.count_gate)) |=> !count_done_irq_o)
		else $error("count done not cleared"); //RULE_13
	AST_PRE_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!prescaler_read_n_i |=> board_data_bus_oe_o)
		else $error("prescaler not driven"); //RULE_11
	AST_TMR_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(prescaler_read_n_i && !timer_select_n_i && !timer_read_n_i)
		|=> (board_data_bus_oe_o && board_data_bus_o == $past(evt_q)))
		else $error("timer data wrong"); //RULE_12
	AST_OVF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cif.msb_fall && evt_q == '1) |=> overflow_irq_o)
		else $error("overflow missed"); //RULE_09
	AST_EVT_INC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cif.msb_fall && !cif.clr) |=> evt_q == $past(evt_q) + 1'b1)
		else $error("event count wrong"); //RULE_08
	AST_GATE_LEN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(cif.count_gate) |-> cif.count_gate [*8])
		else $error("gate too short"); //RULE_03
endmodule // gfc_counter
`default_nettype wire

// ===== hw/gfc_pkg.sv
package gfc_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned TB_HZ         = 2_000_000;
	localparam int unsigned TB_DIV        = CLK_HZ / TB_HZ;
	localparam int unsigned GATE_LONG_MS  = 200;
	localparam int unsigned GATE_MID_MS   = 20;
	localparam int unsigned GATE_SHORT_MS = 2;
	localparam int unsigned GATE_LONG_TB  = GATE_LONG_MS * (TB_HZ / 1000);
	localparam int unsigned GATE_MID_TB   = GATE_MID_MS * (TB_HZ / 1000);
	localparam int unsigned GATE_SHORT_TB = GATE_SHORT_MS * (TB_HZ / 1000);
	localparam int unsigned NOMINAL_IN_HZ = 5_350_000;
	localparam int unsigned PRE_W         = 8;
	localparam int unsigned STAGE_W       = 4;
	localparam int unsigned EVT_W         = 16;
	localparam int unsigned GT_W          = 20;
	localparam logic [PRE_W-1:0] PRE_RST  = 8'h00;
	localparam logic [EVT_W-1:0] EVT_RST  = 16'h0000;
	typedef enum logic [2:0] {
		GFC_RES_10HZ,
		GFC_RES_100HZ,
		GFC_RES_1KHZ,
		GFC_RES_10KHZ,
		GFC_RES_100KHZ,
		GFC_RES_1MHZ
	} gfc_res_e;
	typedef enum logic [1:0] {
		GFC_IDLE,
		GFC_GATE,
		GFC_DONE
	} gfc_state_e;
endpackage

// ===== hw/gfc_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gfc_cnt_if;
	import gfc_pkg::*;
	logic             tb_en;
	logic             count_gate;
	logic             edge_in;
	logic             clr;
	logic [PRE_W-1:0] pre_val;
	logic             msb_fall;
	modport gate (output tb_en, output count_gate);
	modport sink (input tb_en, input count_gate);
	modport pre (input edge_in, input clr, output pre_val, output msb_fall);
	modport drv (output edge_in, output clr, input pre_val, input msb_fall);
endinterface
`default_nettype wire

// ===== hw/gfc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module gfc_prescaler
	import gfc_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// prescaler side
	gfc_cnt_if.pre    p
);
	logic [STAGE_W-1:0] lo_q, lo_d, hi_q, hi_d;
	logic               fall_q, fall_d;

	// two cascaded divide-by-16 stages
	always_comb begin
		lo_d   = lo_q;
		hi_d   = hi_q;
		fall_d = 1'b0;
		if (p.clr) begin
			lo_d = PRE_RST[STAGE_W-1:0];
			hi_d = PRE_RST[PRE_W-1:STAGE_W];
		end else if (p.edge_in) begin //RULE_07
			lo_d = lo_q + 4'h1;
			if (lo_q == 4'hf) begin
				hi_d = hi_q + 4'h1;
				fall_d = (hi_q == 4'hf); //RULE_08
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin //RULE_15
			lo_q   <= 4'h0;
			hi_q   <= 4'h0;
			fall_q <= 1'b0;
		end else begin
			lo_q   <= lo_d;
			hi_q   <= hi_d;
			fall_q <= fall_d;
		end
	end

	assign p.pre_val  = {hi_q, lo_q};
	assign p.msb_fall = fall_q;

	AST_PRE_WRAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(p.edge_in && !p.clr && {hi_q, lo_q} == 8'hff) |=> (p.msb_fall && {hi_q, lo_q} == 8'h00))
		else $error("prescaler wrap missed"); //RULE_07
endmodule // gfc_prescaler
`default_nettype wire

// ===== hw/gfc_gate_timer.sv
`timescale 1ns/10ps
`default_nettype none
module gfc_gate_timer
	import gfc_pkg::*;
(
	// clock and reset
	input  wire logic     clk_i,
	input  wire logic     sys_rst_i,
	// control
	input  wire logic     start_i,
	input  wire gfc_res_e res_i,
	// gate out
	gfc_cnt_if.gate       g
);
	logic [2:0]      div_q, div_d;
	logic            tb_q, tb_d;
	logic [GT_W-1:0] cnt_q, cnt_d;
	logic            gate_q, gate_d;
	logic [GT_W-1:0] len;

	// gate length by resolution; 1 kHz and coarser share the shortest gate
	always_comb begin
		case (res_i) //RULE_03 RULE_04
			GFC_RES_10HZ:  len = GT_W'(GATE_LONG_TB);
			GFC_RES_100HZ: len = GT_W'(GATE_MID_TB);
			default:       len = GT_W'(GATE_SHORT_TB);
		endcase
	end

	always_comb begin
		div_d  = (div_q == 3'(TB_DIV - 1)) ? 3'h0 : div_q + 3'h1; //RULE_01
		tb_d   = (div_q == 3'(TB_DIV - 1));
		cnt_d  = cnt_q;
		gate_d = gate_q;
		if (start_i && !gate_q) begin
			// realign the divider so the window is len*5 cycles, or len*5-5 if div_q was 4 when start was taken
			div_d  = 3'h1; //RULE_01
			cnt_d  = len;
			gate_d = 1'b1;
		end else if (gate_q && tb_q) begin //RULE_02
			cnt_d = cnt_q - 1'b1;
			if (cnt_q == 1) gate_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_q  <= 3'h0;
			tb_q   <= 1'b0;
			cnt_q  <= '0;
			gate_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tb_q   <= tb_d;
			cnt_q  <= cnt_d;
			gate_q <= gate_d;
		end
	end

	assign g.tb_en      = tb_q;
	assign g.count_gate = gate_q;

	AST_TB_SPACING: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(tb_q && gate_q && cnt_q > GT_W'(1)) |=> !tb_q [*4] ##1 tb_q)
		else $error("timebase not one in five"); //RULE_01
endmodule // gfc_gate_timer
`default_nettype wire

// ===== dv/gfc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module gfc_host_model (
	// clock
	input  wire logic        clk_i,
	// board data bus
	input  wire logic [15:0] bus_i,
	input  wire logic        bus_oe_i,
	// strobes and ack latch
	output logic             prescaler_read_n_o,
	output logic             timer_select_n_o,
	output logic             timer_read_n_o,
	output logic             ack_wr_o,
	output logic             ack_data_o
);
	initial begin
		prescaler_read_n_o = 1'b1;
		timer_select_n_o   = 1'b1;
		timer_read_n_o     = 1'b1;
		ack_wr_o           = 1'b0;
		ack_data_o         = 1'b0;
	end

	// strobes held until the bus is seen driven, 8 cycles at most
	task automatic rd(input logic pre, output logic [15:0] d);
		int w;
		w = 0;
		@(negedge clk_i);
		prescaler_read_n_o = !pre;
		timer_select_n_o   = pre;
		timer_read_n_o     = pre;
		do begin
			@(negedge clk_i);
			w++;
		end while (bus_oe_i !== 1'b1 && w < 8);
		d                  = bus_i;
		prescaler_read_n_o = 1'b1;
		timer_select_n_o   = 1'b1;
		timer_read_n_o     = 1'b1;
		@(negedge clk_i);
	endtask

	task automatic wr_ack(input logic v);
		@(negedge clk_i);
		ack_wr_o   = 1'b1;
		ack_data_o = v;
		@(negedge clk_i);
		ack_wr_o   = 1'b0;
	endtask
endmodule // gfc_host_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb import gfc_pkg::*;;
	localparam int LIMIT = 80000;
	localparam logic [15:0] GLEN = 16'(GATE_SHORT_TB * TB_DIV);
	logic        clk_i, sys_rst_i, start_i, freq_in_i;
	logic [2:0]  res_i;
	logic        pre_n, sel_n, rd_n, ack_wr, ack_d;
	logic [15:0] bus;
	logic        oe, gate, ovf, done, ack;
	int          err_total, num_checks, cyc;

	gfc_counter gfc_counter_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
		.res_i(res_i), .freq_in_i(freq_in_i),
		.prescaler_read_n_i(pre_n), .timer_select_n_i(sel_n),
		.timer_read_n_i(rd_n), .ack_wr_i(ack_wr), .ack_data_i(ack_d),
		.board_data_bus_o(bus), .board_data_bus_oe_o(oe),
		.count_gate_o(gate), .overflow_irq_o(ovf),
		.count_done_irq_o(done), .count_done_ack_o(ack)
	);
	gfc_host_model gfc_host_model_inst (
		.clk_i(clk_i), .bus_i(bus), .bus_oe_i(oe),
		.prescaler_read_n_o(pre_n), .timer_select_n_o(sel_n),
		.timer_read_n_o(rd_n), .ack_wr_o(ack_wr), .ack_data_o(ack_d)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			freq_in_i = 1'b1;
			@(negedge clk_i);
			freq_in_i = 1'b0;
			@(negedge clk_i);
		end
	endtask

	// a second start mid-gate must not stretch the window
	task automatic run_gate(input logic [2:0] r, input int n, output int len);
		int w;
		w = 0;
		res_i   = r;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		while (gate !== 1'b1 && w < 10) begin
			@(negedge clk_i);
			w++;
		end
		pulses(n);
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		len = 2 * n + 1;
		while (gate === 1'b1 && len < 30000) begin
			@(negedge clk_i);
			len++;
		end
	endtask

	task automatic t_reset;
		chk({11'h000, ovf, done, ack, gate, oe}, 16'h0000);
	endtask

	task automatic t_count;
		int len;
		logic [15:0] d;
		gfc_host_model_inst.wr_ack(1'b1);
		chk(16'(ack), 16'h0001);
		run_gate(3'h2, 300, len);
		chk(16'(len), GLEN);
		repeat (2) @(negedge clk_i);
		chk(16'(done), 16'h0001);
		pulses(3);
		gfc_host_model_inst.rd(1'b1, d);
		chk(d, 16'h002c);
		gfc_host_model_inst.rd(1'b0, d);
		chk(d, 16'h0001);
		chk(16'(ovf), 16'h0000);
		gfc_host_model_inst.wr_ack(1'b0);
		repeat (3) @(negedge clk_i);
		chk({14'h0000, ack, done}, 16'h0000);
	endtask

	// ack low: gate end must not raise the request
	task automatic t_gate(input logic [2:0] r);
		int len;
		logic [15:0] d;
		run_gate(r, 0, len);
		chk(16'(len), GLEN);
		repeat (2) @(negedge clk_i);
		chk(16'(done), 16'h0000);
		gfc_host_model_inst.rd(1'b1, d);
		chk(d, 16'h0000);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		sys_rst_i = 1'b1;
		start_i   = 1'b0;
		res_i     = 3'h0;
		freq_in_i = 1'b0;
		repeat (4) @(negedge clk_i);
		sys_rst_i = 1'b0;
		t_reset();
		t_count();
		t_gate(3'h4);
		t_gate(3'h7);
		stop_test();
	end
endmodule // tb
`default_nettype wire
